// ==== hdl/port_cfg.svh ====
// Register defaults, field positions and timing constants of the port block.
// Assumes inclusion by bare name from the design modules.
`ifndef PORT_CFG_SVH_CFG
`define PORT_CFG_SVH_CFG
// ============================================================
// Register indices
`define REG_STATUS 4'h0
`define REG_STAGE 4'h1
`define REG_CTRL1 4'h2
`define REG_CTRL2 4'h3
`define REG_LED1H 4'h4
`define REG_LED1L 4'h5
`define REG_LED2H 4'h6
`define REG_LED2L 4'h7
`define REG_PARITY 4'h8
// ============================================================
// Reset values
`define RST_STAGE 8'h80
`define RST_CTRL1 8'h21
`define RST_CTRL2 8'h21
`define RST_ZERO 8'h00
`define STAGE_MASK 8'hE0
`define STATUS_MASK 8'hBB
`define CTRL2_MASK 8'hBF
// ============================================================
// Field positions
`define ST_POWER_ON 7
`define ST_OVERTEMP 5
`define ST_CQ_OL 4
`define ST_IQ_OL 3
`define ST_REG_LOW 1
`define ST_PARITY 0
`define STAGE_HI 7
`define STAGE_LO 5
`define CQ_ENABLE_BIT 7
`define PAR_STATUS 7
`define PAR_STAGE 6
`define PAR_CTRL1 5
`define PAR_CTRL2 4
`define PAR_LED1H 3
// ============================================================
// Stage codes
`define STAGE_OFF 3'h0
`define STAGE_TRISTATE 3'h4
// ============================================================
// Startup parameters (mA, us, ms)
`define CQ_CUTOFF_MA 220
`define CQ_CUTOFF_DELAY_US 100
`define CQ_RESTART_MS 25
`define CQ_DEBOUNCE_US 5
`define SUPPLY_CUTOFF_US 0
`define SUPPLY_RESTART_MS 64
`define INPUT_DEBOUNCE_US 5
`define CLK_MHZ 250
`endif

// ==== hdl/port_pkg.sv ====
// Types shared by the port block modules.
// Assumes the configuration header sits beside it.
package port_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_CHECK = 3'b010,
        WR_COMMIT = 3'b100
    } write_state_e;
endpackage : port_pkg

// ==== hdl/fault_if.sv ====
// Carries sampled fault levels from the synchroniser to the bank.
// Assumes one clock domain, sys_clk.
interface fault_if;
    logic power_on;
    logic overtemp;
    logic cq_overload;
    logic iq_overload;
    logic regulator_low;
    modport src (output power_on, overtemp, cq_overload, iq_overload,
        regulator_low);
    modport dst (input power_on, overtemp, cq_overload, iq_overload,
        regulator_low);
endinterface : fault_if

// ==== hdl/fault_sync.sv ====
// Two-flop synchroniser for the asynchronous fault inputs.
// Assumes raw fault levels arrive from analog monitors.
module fault_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] raw_faults,
    fault_if.src faults
);
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] sync;
    } sync_s;
    sync_s state;
    sync_s next_state;

    always_comb begin
        next_state.meta = raw_faults;
        next_state.sync = state.meta;
        if (rst) begin
            next_state = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    assign faults.power_on = state.sync[4];
    assign faults.overtemp = state.sync[3];
    assign faults.cq_overload = state.sync[2];
    assign faults.iq_overload = state.sync[1];
    assign faults.regulator_low = state.sync[0];
endmodule : fault_sync

// ==== hdl/port_config_reset_and_irq.sv ====
// Register bank with startup defaults, fault flags and open-drain interrupt.
// Assumes a serial front end delivers decoded writes and reads on sys_clk.
`include "port_cfg.svh"

// Operation
// [R1] Startup C/Q cutoff 220 mA, delay 100 us, restart 25 ms, debounce 5 us.
// [R2] Startup supply cutoff delay 0 us, restart 64 ms, input debounce 5 us.
// [R3] Stage select resets to 100, tristate; lower five bits unused.
// [R4] Fault flags, LED patterns and parity register reset to zero.
// [R5] Control one resets to 0x21; control two to 0x21, bit 6 unused.
// [R6] Interrupt output is open drain: only pulls low, never drives high.
// [R7] Any fault event pulls the interrupt line low.
// [R8] Host holds the interrupt line high by pull-up and wires it directly.
// [R9] Slow decay: high-side turn-off turns low-side switch on.
// [R10] Supply-tied load: low-side turn-off turns high-side switch on.
// [R11] Parity mismatch sets the parity-error flag and raises the interrupt.
// [R12] Direct jump between active stages is refused with a parity error.
module port_config_reset_and_irq (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_valid,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] wr_parity,
    input wire logic seq_valid,
    input wire logic [55:0] seq_data,
    input wire logic [7:0] seq_parity,
    input wire logic rd_valid,
    input wire logic [3:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic [4:0] raw_faults,
    input wire logic cq_high_side_cmd,
    input wire logic cq_low_side_cmd,
    output logic high_side_switch,
    output logic low_side_switch,
    output logic [7:0] cq_cutoff_current_ma,
    output logic [7:0] cq_cutoff_delay_us,
    output logic [7:0] cq_restart_delay_ms,
    output logic [7:0] cq_debounce_time_us,
    output logic [7:0] supply_line_cutoff_delay_us,
    output logic [7:0] supply_line_restart_delay_ms,
    output logic [7:0] input_debounce_default_us,
    output logic irq_o,
    output logic irq_oe
);
    // ============================================================
    // State
    typedef struct packed {
        port_pkg::byte_t fault_flags;
        port_pkg::byte_t output_stage_select;
        port_pkg::byte_t cq_protection_control;
        port_pkg::byte_t input_supply_control;
        port_pkg::byte_t [3:0] led;
        port_pkg::byte_t computed_parity;
        port_pkg::byte_t rd_data;
        logic hs_prev;
        logic ls_prev;
        logic high_side_switch;
        logic low_side_switch;
    } bank_s;
    bank_s state;
    bank_s next_state;

    fault_if faults ();

    fault_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .raw_faults(raw_faults),
        .faults(faults)
    );

    // ============================================================
    // Helpers
    function automatic logic [2:0] triple_parity(input logic [7:0] d);
        triple_parity = {^{d[6], d[4], d[2], d[0]},
            ^{d[7], d[5], d[3], d[1]}, ^d};
    endfunction : triple_parity

    // Off and tristate are the only passive codes
    function automatic logic stage_active(input logic [2:0] s);
        stage_active = (s != `STAGE_OFF) && (s != `STAGE_TRISTATE);
    endfunction : stage_active

    function automatic logic jump_bad(input logic [7:0] old_v,
        input logic [7:0] new_v);
        jump_bad = stage_active(old_v[`STAGE_HI:`STAGE_LO]) &&
            stage_active(new_v[`STAGE_HI:`STAGE_LO]) &&
            (old_v[`STAGE_HI:`STAGE_LO] != new_v[`STAGE_HI:`STAGE_LO]);
    endfunction : jump_bad

    logic [7:0] seq_byte [7];
    logic [7:0] seq_calc;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_seq
            assign seq_byte[gi] = seq_data[gi*8 +: 8];
            assign seq_calc[`PAR_STAGE - gi] = ^seq_data[gi*8 +: 8];
        end
    endgenerate
    assign seq_calc[`PAR_STATUS] = ^state.fault_flags;

    // ============================================================
    // Next state
    always_comb begin
        logic write_ok;
        logic par_err;
        write_ok = 1'b0;
        par_err = 1'b0;
        next_state = state;
        // Hardware set wins over any clear in the same cycle
        next_state.fault_flags[`ST_POWER_ON] = state.fault_flags[`ST_POWER_ON]
            | faults.power_on; // [R7]
        next_state.fault_flags[`ST_OVERTEMP] = state.fault_flags[`ST_OVERTEMP]
            | faults.overtemp; // [R7]
        next_state.fault_flags[`ST_CQ_OL] = state.fault_flags[`ST_CQ_OL]
            | faults.cq_overload; // [R7]
        next_state.fault_flags[`ST_IQ_OL] = state.fault_flags[`ST_IQ_OL]
            | faults.iq_overload;
        next_state.fault_flags[`ST_REG_LOW] = state.fault_flags[`ST_REG_LOW]
            | faults.regulator_low;
        if (wr_valid) begin
            write_ok = triple_parity(wr_data) == wr_parity;
            if (wr_addr == `REG_STAGE &&
                jump_bad(state.output_stage_select, wr_data)) begin
                write_ok = 1'b0; // [R12]
            end
            if (!write_ok) begin
                par_err = 1'b1;
                next_state.fault_flags[`ST_PARITY] = 1'b1; // [R11]
            end else begin
                unique case (wr_addr)
                    `REG_STAGE: begin
                        next_state.output_stage_select = wr_data &
                            `STAGE_MASK;
                        next_state.computed_parity[`PAR_STAGE] = ^wr_data;
                    end
                    `REG_CTRL1: begin
                        next_state.cq_protection_control = wr_data;
                        next_state.computed_parity[`PAR_CTRL1] = ^wr_data;
                    end
                    `REG_CTRL2: begin
                        next_state.input_supply_control = wr_data &
                            `CTRL2_MASK;
                        next_state.computed_parity[`PAR_CTRL2] = ^wr_data;
                    end
                    `REG_LED1H, `REG_LED1L, `REG_LED2H, `REG_LED2L: begin
                        next_state.led[wr_addr[1:0]] = wr_data;
                        next_state.computed_parity[`PAR_LED1H -
                            wr_addr[1:0]] = ^wr_data;
                    end
                    // Status, parity and spare indices take no data
                    default: begin
                    end
                endcase
            end
        end else if (seq_valid) begin
            next_state.computed_parity = seq_calc;
            // A direct jump between active stages rejects the whole sequence
            if (seq_calc[6:0] != seq_parity[6:0] ||
                jump_bad(state.output_stage_select, seq_byte[0])) begin
                par_err = 1'b1;
                next_state.fault_flags[`ST_PARITY] = 1'b1; // [R11] [R12]
            end else begin
                next_state.output_stage_select = seq_byte[0] & `STAGE_MASK;
                next_state.cq_protection_control = seq_byte[1];
                next_state.input_supply_control = seq_byte[2] & `CTRL2_MASK;
                for (int i = 0; i < 4; i++) begin
                    next_state.led[i] = seq_byte[3 + i];
                end
            end
        end
        if (rd_valid) begin
            unique case (rd_addr)
                `REG_STATUS: begin
                    next_state.rd_data = state.fault_flags;
                    // Read clears, except events arriving this cycle
                    next_state.fault_flags = next_state.fault_flags &
                        ~state.fault_flags |
                        {faults.power_on, 1'b0, faults.overtemp,
                        faults.cq_overload, faults.iq_overload, 1'b0,
                        faults.regulator_low, 1'b0};
                    if (par_err) begin
                        next_state.fault_flags[`ST_PARITY] = 1'b1;
                    end
                end
                `REG_STAGE: next_state.rd_data = state.output_stage_select;
                `REG_CTRL1: next_state.rd_data = state.cq_protection_control;
                `REG_CTRL2: next_state.rd_data = state.input_supply_control;
                `REG_LED1H, `REG_LED1L, `REG_LED2H, `REG_LED2L:
                    next_state.rd_data = state.led[rd_addr[1:0]];
                `REG_PARITY: next_state.rd_data = state.computed_parity;
                default: next_state.rd_data = `RST_ZERO;
            endcase
        end
        // Slow decay and supply-tied load: complementary switch conducts on turn-off
        next_state.hs_prev = cq_high_side_cmd;
        next_state.ls_prev = cq_low_side_cmd;
        next_state.high_side_switch = cq_high_side_cmd |
            (state.ls_prev & ~cq_low_side_cmd); // [R10]
        next_state.low_side_switch = cq_low_side_cmd |
            (state.hs_prev & ~cq_high_side_cmd); // [R9]
        if (rst) begin
            next_state = '0; // [R4]
            next_state.output_stage_select = `RST_STAGE; // [R3]
            next_state.cq_protection_control = `RST_CTRL1; // [R5] [R1]
            next_state.input_supply_control = `RST_CTRL2; // [R5] [R2]
        end
    end

    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    // ============================================================
    // Outputs
    assign rd_data = state.rd_data;
    assign high_side_switch = state.high_side_switch;
    assign low_side_switch = state.low_side_switch;
    assign cq_cutoff_current_ma = 8'(`CQ_CUTOFF_MA); // [R1]
    assign cq_cutoff_delay_us = 8'(`CQ_CUTOFF_DELAY_US); // [R1]
    assign cq_restart_delay_ms = 8'(`CQ_RESTART_MS); // [R1]
    assign cq_debounce_time_us = 8'(`CQ_DEBOUNCE_US); // [R1]
    assign supply_line_cutoff_delay_us = 8'(`SUPPLY_CUTOFF_US); // [R2]
    assign supply_line_restart_delay_ms = 8'(`SUPPLY_RESTART_MS); // [R2]
    assign input_debounce_default_us = 8'(`INPUT_DEBOUNCE_US); // [R2]
    // Never drives high; host pull-up supplies the high level
    assign irq_o = 1'b0; // [R6]
    assign irq_oe = |(state.fault_flags & `STATUS_MASK); // [R7] [R11] [R8]
endmodule : port_config_reset_and_irq

// ==== testbench/host_irq_model.sv ====
// Host side of the interrupt line: pull-up and the input it feeds.
// Assumes the device only ever pulls the line low.
module host_irq_model (
    input wire logic irq_o,
    input wire logic irq_oe,
    output logic irq_line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line rises through the resistor, so it is never left unknown
    assign irq_line_n = irq_oe ? irq_o : 1'b1;
endmodule : host_irq_model

// ==== testbench/port_config_reset_and_irq_properties.sv ====
// Concurrent checks on the port bank, seen from its top-level ports.
// Assumes one clock, sys_clk, and a synchronous active-high rst.
module port_config_reset_and_irq_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] wr_parity,
    input wire logic rd_valid,
    input wire logic [3:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic [4:0] raw_faults,
    input wire logic cq_high_side_cmd,
    input wire logic cq_low_side_cmd,
    input wire logic high_side_switch,
    input wire logic low_side_switch,
    input wire logic [7:0] cq_cutoff_current_ma,
    input wire logic [7:0] supply_line_restart_delay_ms,
    input wire logic irq_o,
    input wire logic irq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [2:0] exp_par;
    assign exp_par = {^{wr_data[6], wr_data[4], wr_data[2], wr_data[0]},
        ^{wr_data[7], wr_data[5], wr_data[3], wr_data[1]}, ^wr_data};
    // ============================================================
    // Assertions
    a_irq_open_drain: assert property (irq_o == 1'b0)
        else $error("interrupt pin driven high");
    a_reset_quiet: assert property ($fell(rst) |-> !irq_oe
        && !high_side_switch && !low_side_switch && rd_data == 8'h00)
        else $error("outputs not clean after reset");
    a_startup_values: assert property (cq_cutoff_current_ma == 8'hDC
        && supply_line_restart_delay_ms == 8'h40)
        else $error("startup value wrong");
    a_stage_default: assert property ($past(rst) && rd_valid
        && rd_addr == 4'h1 |=> rd_data[7:5] == 3'b100)
        else $error("stage select not tristate after reset");
    a_fault_irq: assert property ($rose(|raw_faults) |-> ##[1:6] irq_oe)
        else $error("fault did not pull interrupt");
    a_parity_irq: assert property (wr_valid && wr_parity != exp_par
        |-> ##[1:3] irq_oe)
        else $error("bad parity did not pull interrupt");
    a_slow_decay: assert property ($fell(cq_high_side_cmd)
        && !cq_low_side_cmd |-> ##[1:2] low_side_switch)
        else $error("low side missing at high side turn-off");
    a_supply_decay: assert property ($fell(cq_low_side_cmd)
        && !cq_high_side_cmd |-> ##[1:2] high_side_switch)
        else $error("high side missing at low side turn-off");
    c_irq: cover property ($rose(irq_oe));
    c_status_read: cover property (rd_valid && rd_addr == 4'h0);
    c_decay: cover property ($rose(low_side_switch));
endmodule : port_config_reset_and_irq_properties

bind port_config_reset_and_irq port_config_reset_and_irq_properties
    port_config_reset_and_irq_properties_i (.*);

// ==== testbench/tb_port_config_reset_and_irq.sv ====
// Self-checking bench: integer model of the bank against the design.
// Assumes design files, host model and checker are compiled first.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t: got %h exp %h", $time, g, e); end end
module tb_port_config_reset_and_irq;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FB[5] = '{1, 3, 4, 5, 7};
    localparam port_pkg::byte_t SV[7] = '{8'hDC, 8'h64, 8'h19, 8'h05,
        8'h00, 8'h40, 8'h05};
    logic sys_clk = 0, rst = 1, wr_valid = 0, seq_valid = 0, rd_valid = 0;
    logic hs_cmd = 0, ls_cmd = 0, hss, lss, irq_o, irq_oe, irq_line_n, seen;
    logic [3:0] wr_addr = 0, rd_addr = 0;
    logic [2:0] wr_parity = 0;
    logic [55:0] seq_data = 0;
    logic [4:0] raw_faults = 0;
    port_pkg::byte_t wr_data = 0, seq_parity = 0, rd_data, v, k[7];
    int num_errors = 0, n_tests = 0, regs[16], st = 0, held = 0, a;
    port_config_reset_and_irq port_config_reset_and_irq_i (.sys_clk, .rst,
        .wr_valid, .wr_addr, .wr_data, .wr_parity, .seq_valid, .seq_data,
        .seq_parity, .rd_valid, .rd_addr, .rd_data, .raw_faults,
        .cq_high_side_cmd(hs_cmd), .cq_low_side_cmd(ls_cmd),
        .high_side_switch(hss), .low_side_switch(lss),
        .cq_cutoff_current_ma(k[0]), .cq_cutoff_delay_us(k[1]),
        .cq_restart_delay_ms(k[2]), .cq_debounce_time_us(k[3]),
        .supply_line_cutoff_delay_us(k[4]),
        .supply_line_restart_delay_ms(k[5]),
        .input_debounce_default_us(k[6]), .irq_o, .irq_oe);
    host_irq_model host_irq_model_i (.irq_o, .irq_oe, .irq_line_n);
    // ============================================================
    // Model and bus tasks
    function automatic int msk(int i);
        return i == 1 ? 8'hE0 : i == 3 ? 8'hBF : 8'hFF;
    endfunction : msk
    function automatic bit active(int s);
        return s != 8'h00 && s != 8'h80;
    endfunction : active
    task automatic rd(int i);
        port_pkg::byte_t e;
        e = 8'(i == 0 ? st : regs[i]);
        rd_valid = 1;
        rd_addr = 4'(i);
        @(negedge sys_clk);
        rd_valid = 0;
        `CHK(rd_data, e)
        // Fault levels still present set their flag again at once
        if (i == 0) st = held;
        // One idle edge so the next request never re-raises a strobe
        @(negedge sys_clk);
    endtask : rd
    task automatic wr(int i, int d, bit bad);
        wr_valid = 1;
        wr_addr = 4'(i);
        wr_data = 8'(d);
        wr_parity = {^{d[6], d[4], d[2], d[0]}, ^{d[7], d[5], d[3], d[1]},
            ^wr_data ^ bad};
        @(negedge sys_clk);
        wr_valid = 0;
        if (bad || (i == 1 && active(regs[1]) && active(d & 8'hE0)
            && (d & 8'hE0) != regs[1])) st |= 1;
        else if (i < 8) begin
            regs[i] = d & msk(i);
            regs[8][7 - i] = ^8'(d);
        end
        @(negedge sys_clk);
    endtask : wr
    task automatic sq(bit bad);
        for (int i = 0; i < 7; i++) begin
            seq_data[i*8 +: 8] = 8'(i ? $urandom & msk(i + 1) : regs[1]);
            v[6 - i] = ^seq_data[i*8 +: 8];
            seq_parity[6 - i] = v[6 - i] ^ (bad && i == 3);
        end
        // Parity register keeps the computed bits even when rejected
        v[7] = ^8'(st);
        regs[8] = v;
        seq_valid = 1;
        @(negedge sys_clk);
        seq_valid = 0;
        if (bad) st |= 1;
        else for (int i = 0; i < 7; i++) regs[i + 1] = seq_data[i*8 +: 8];
        @(negedge sys_clk);
    endtask : sq
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // ============================================================
    // Stimulus
    initial forever #2 sys_clk = ~sys_clk;
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        print_verdict;
    end
    initial begin
        void'($urandom(69));
        regs = '{default: 0};
        regs[1] = 8'h80;
        regs[2] = 8'h21;
        regs[3] = 8'h21;
        repeat (16) @(negedge sys_clk);
        rst = 0;
        rd(1);
        for (int i = 0; i < 9; i++) rd(i);
        for (int i = 0; i < 7; i++) `CHK(k[i], SV[i])
        repeat (40) begin
            a = 1 + $urandom % 15;
            if (a == 8) a = 9;
            wr(a, $urandom % 256, $urandom % 6 == 0);
            rd(a);
            `CHK(irq_line_n, 1'(st == 0))
            rd(0);
            rd(8);
        end
        for (int b = 0; b < 2; b++) begin
            sq(b[0]);
            for (int i = 1; i < 10; i++) rd(i % 9);
        end
        for (int b = 0; b < 5; b++) begin
            raw_faults = 5'(1 << b);
            held = 1 << FB[b];
            st |= held;
            repeat (6) @(negedge sys_clk);
            `CHK(irq_line_n, 1'b0)
            rd(0);
            raw_faults = 0;
            held = 0;
            repeat (8) @(negedge sys_clk);
            rd(0);
            rd(0);
        end
        for (int j = 0; j < 2; j++) begin
            {hs_cmd, ls_cmd} = j ? 2'b01 : 2'b10;
            repeat (3) @(negedge sys_clk);
            {hs_cmd, ls_cmd} = 2'b00;
            seen = 0;
            repeat (2) begin
                @(negedge sys_clk);
                seen |= j ? hss : lss;
            end
            `CHK(seen, 1'b1)
            // Decay conduction is a single cycle, then the switch opens
            `CHK(j ? hss : lss, 1'b0)
        end
        print_verdict;
    end
endmodule : tb_port_config_reset_and_irq
